// ==== hdl/sac_consts.vh ====
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// register map, 8-bit word index on the plain register port
`define SAC_GRP_DREG 5'h00
`define SAC_GRP_DLO 5'h01
`define SAC_GRP_DHI 5'h02
`define SAC_GRP_ACC 5'h04
`define SAC_GRP_PTR 5'h06
`define SAC_GRP_LOOP 5'h07
`define SAC_GRP_IDX 6'h10
`define SAC_GRP_MOD 6'h11
`define SAC_GRP_LEN 6'h12
`define SAC_GRP_BASE 6'h13
`define SAC_OFS_STAT 8'h50
`define SAC_OFS_CIRC 8'h51

// accumulator sub-views, addr[1:0] inside one accumulator's slot
`define SAC_ACC_WORD 2'h0
`define SAC_ACC_EXT 2'h1
`define SAC_ACC_LO 2'h2
`define SAC_ACC_HI 2'h3

// pointer file slots for the stack and frame pointers
`define SAC_PTR_STACK 3'h6
`define SAC_PTR_FRAME 3'h7
`define SAC_STACK_STEP 32'h00000004

// loop register slots inside the loop group
`define SAC_LOOP_TOP0 3'h0
`define SAC_LOOP_BOT0 3'h1
`define SAC_LOOP_CNT0 3'h2
`define SAC_LOOP_TOP1 3'h3
`define SAC_LOOP_BOT1 3'h4
`define SAC_LOOP_CNT1 3'h5

// arithmetic status word bit positions
`define SAC_ST_ZERO 0
`define SAC_ST_NEG 1
`define SAC_ST_CC 5
`define SAC_ST_QUOT 6
`define SAC_ST_RND 8
`define SAC_ST_C0 12
`define SAC_ST_C0DUP 13
`define SAC_ST_C1 14
`define SAC_ST_AV0 16
`define SAC_ST_FIRST_ACC_STICKY_OVERFLOW 17
`define SAC_ST_AV1 18
`define SAC_ST_SECOND_ACC_STICKY_OVERFLOW 19
`define SAC_ST_V 24
`define SAC_ST_VCOPY 25
`define SAC_ST_VS 26
`define SAC_STAT_RST 32'h00000000
`define SAC_STAT_WMASK 32'h070f7163

// result destinations
`define SAC_DST_NONE 3'h0
`define SAC_DST_ACC 3'h1
`define SAC_DST_DREG 3'h2
`define SAC_DST_DLO 3'h3
`define SAC_DST_DHI 3'h4

// destination widths for the conditioning unit
`define SAC_W16 2'h0
`define SAC_W32 2'h1
`define SAC_W40 2'h2

`endif

// ==== hdl/sac_sat_unit.v ====
`timescale 1ns/10ps
`include "sac_consts.vh"

module sac_sat_unit (
  input wire [47:0] raw_val,
  input wire [1:0] width_sel,
  input wire sat_en,
  input wire uns_en,
  output reg [39:0] out_val,
  output reg ovf,
  output reg neg_flag,
  output reg zero_flag
);

  reg [47:0] hi_lim;
  reg [47:0] lo_lim;
  reg fits;
  reg [47:0] chosen;

  // limits per width; no 8-bit width exists, so the extension byte
  // is never treated as a fraction
  always @*
  begin
    hi_lim = 48'h0;
    lo_lim = 48'h0;
    fits = 1'b0;
    chosen = raw_val;
    case (width_sel)
      `SAC_W16:
      begin
        hi_lim = uns_en ? 48'h00000000ffff : 48'h000000007fff; // see RULE15
        lo_lim = uns_en ? 48'h0 : 48'hffffffff8000; // see RULE15
      end
      `SAC_W32:
      begin
        hi_lim = uns_en ? 48'h0000ffffffff : 48'h00007fffffff; // see RULE15
        lo_lim = uns_en ? 48'h0 : 48'hffff80000000; // see RULE15
      end
      default:
      begin
        hi_lim = uns_en ? 48'h00ffffffffff : 48'h007fffffffff; // see RULE15
        lo_lim = uns_en ? 48'h0 : 48'hff8000000000; // see RULE15
      end
    endcase
    // unsigned views 0.16/0.32/8.32 versus signed 1.15/1.31/9.31
    if (uns_en) // see RULE11
      fits = !raw_val[47] && (raw_val <= hi_lim);
    else
      fits = ($signed(raw_val) >= $signed(lo_lim)) &&
             ($signed(raw_val) <= $signed(hi_lim));
    // the true sign of the wide result picks the rail
    if (sat_en && !fits)
      chosen = raw_val[47] ? lo_lim : hi_lim; // see RULE13 see RULE14
    // without clamping only the low bits survive in the caller
    out_val = chosen[39:0]; // see RULE19
    // a clamped result never reports overflow
    ovf = !fits && !sat_en; // see RULE16
    case (width_sel)
      `SAC_W16:
      begin
        neg_flag = chosen[15];
        zero_flag = (chosen[15:0] == 16'h0);
      end
      `SAC_W32:
      begin
        neg_flag = chosen[31];
        zero_flag = (chosen[31:0] == 32'h0);
      end
      default:
      begin
        neg_flag = chosen[39];
        zero_flag = (chosen[39:0] == 40'h0);
      end
    endcase
  end

endmodule

// ==== hdl/sac_core_state.v ====
// Summary of operation
// RULE1 - accumulators: whole, word, halves, extension byte
// RULE2 - eight data registers with two halves
// RULE3 - pointers are whole 32-bit byte addresses only
// RULE4 - stack pointer marks last byte, grows down
// RULE5 - two loop sets: top, bottom, count
// RULE6 - four index/modify/length/base groups; zero disables
// RULE7 - status word holds active-high result flags
// RULE8 - pointer and address ops leave flags alone
// RULE9 - sticky overflow holds until software clears
// RULE10 - condition bit changed only by its instructions
// RULE11 - fractional formats follow destination width
// RULE12 - eight-bit contents never treated as fractions
// RULE13 - positive overflow clamps to largest positive
// RULE14 - negative overflow clamps to most negative
// RULE15 - clamp limits per 16, 32, 40 bits
// RULE16 - saturating operation never sets overflow
// RULE17 - accumulators saturate at 40, optional 32
// RULE18 - data registers saturate only when asked
// RULE19 - unsaturated results keep the low bits
// RULE20 - unit zero to accumulator zero, one to one
// RULE21 - two independent address generator sections
// RULE22 - status bit selects biased or unbiased rounding
// RULE23 - nonzero length enables circular wrapping
// RULE24 - flags commit with the result
`timescale 1ns/10ps
`include "sac_consts.vh"

module sac_core_state (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wr_data,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rd_data,
  input wire [1:0] op_valid,
  input wire [5:0] op_dest,
  input wire [5:0] op_didx,
  input wire [95:0] op_result,
  input wire [1:0] op_sat,
  input wire [1:0] op_sat32,
  input wire [1:0] op_uns,
  input wire [1:0] op_carry,
  input wire quot_we,
  input wire quot_val,
  input wire cc_we,
  input wire cc_val,
  input wire stack_push,
  input wire stack_pop,
  input wire [1:0] ag_req,
  input wire [3:0] ag_ireg,
  input wire [3:0] ag_mreg,
  input wire [1:0] ag_indexed,
  output reg [63:0] ag_addr,
  output reg [1:0] ag_valid,
  output reg [31:0] arith_status_word,
  output reg round_select,
  output reg condition_bit,
  output reg [31:0] stack_top_ptr,
  output reg [3:0] circ_wrap_en,
  output reg [39:0] accumulator_zero,
  output reg [39:0] accumulator_one
);

  reg [39:0] acc_reg [0:1];
  reg [31:0] dreg_reg [0:7];
  reg [31:0] ptr_reg [0:7];
  reg [31:0] loop_reg [0:5];
  reg [31:0] idx_reg [0:3];
  reg [31:0] mod_reg [0:3];
  reg [31:0] len_reg [0:3];
  reg [31:0] base_reg [0:3];
  reg [31:0] status_next;
  reg [31:0] rd_next;
  reg [1:0] is_acc;
  reg [1:0] is_dreg;
  reg v_any;
  reg flag_sel;
  wire [79:0] sat_val;
  wire [1:0] sat_ovf;
  wire [1:0] sat_neg;
  wire [1:0] sat_zero;
  wire bus_stat_wr;
  // each process keeps its own loop variable so none has two drivers
  integer i;
  integer c, g, w;

  assign bus_stat_wr = reg_wr && (reg_addr == `SAC_OFS_STAT);

  // one conditioning unit per arithmetic lane, each tied to its own
  // accumulator so the two lanes never share a clamp path
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1)
    begin : g_unit
      wire [2:0] dst;
      wire [1:0] wsel;
      wire sen;
      assign dst = op_dest[3*k+2:3*k];
      // accumulators clamp at 40 bits unless the 32-bit mode is picked
      assign wsel = (dst == `SAC_DST_ACC) ?
                    (op_sat32[k] ? `SAC_W32 : `SAC_W40) : // see RULE17
                    ((dst == `SAC_DST_DREG) ? `SAC_W32 : `SAC_W16);
      // accumulators always clamp; data registers only on request
      assign sen = (dst == `SAC_DST_ACC) ? 1'b1 : op_sat[k]; // see RULE18
      sac_sat_unit u_sat (
        .raw_val(op_result[48*k+47:48*k]),
        .width_sel(wsel),
        .sat_en(sen),
        .uns_en(op_uns[k]),
        .out_val(sat_val[40*k+39:40*k]),
        .ovf(sat_ovf[k]),
        .neg_flag(sat_neg[k]),
        .zero_flag(sat_zero[k])
      );
    end
  endgenerate

  // destination classes for the flag logic
  always @*
  begin
    for (c = 0; c < 2; c = c + 1)
    begin
      is_acc[c] = op_valid[c] && (op_dest[3*c+:3] == `SAC_DST_ACC);
      is_dreg[c] = op_valid[c] &&
                   (op_dest[3*c+:3] != `SAC_DST_ACC) &&
                   (op_dest[3*c+:3] != `SAC_DST_NONE);
    end
    v_any = (is_dreg[0] && sat_ovf[0]) || (is_dreg[1] && sat_ovf[1]);
    // unit zero reports zero/negative when both lanes retire together
    flag_sel = !op_valid[0];
  end

  // next status word: software write first, hardware events after it so
  // a sticky set in the clearing cycle is never lost
  always @*
  begin
    status_next = arith_status_word;
    if (bus_stat_wr)
      status_next = reg_wr_data & `SAC_STAT_WMASK;
    // only arithmetic retirements, the quotient and condition writes and the bus touch flags; pointer, stack and
    // address-generator activity has no path here
    if (op_valid != 2'h0) // see RULE8 see RULE24
    begin
      status_next[`SAC_ST_ZERO] = sat_zero[flag_sel]; // see RULE7
      status_next[`SAC_ST_NEG] = sat_neg[flag_sel]; // see RULE7
      status_next[`SAC_ST_V] = v_any;
      status_next[`SAC_ST_VCOPY] = v_any;
    end
    if (op_valid[0])
    begin
      status_next[`SAC_ST_C0] = op_carry[0];
      status_next[`SAC_ST_C0DUP] = op_carry[0];
    end
    if (op_valid[1])
      status_next[`SAC_ST_C1] = op_carry[1];
    if (is_acc[0])
      status_next[`SAC_ST_AV0] = sat_ovf[0];
    if (is_acc[1])
      status_next[`SAC_ST_AV1] = sat_ovf[1];
    // sticky bits set here from hardware; the masked bus write above can set them too
    if (is_acc[0] && sat_ovf[0]) // see RULE9
      status_next[`SAC_ST_FIRST_ACC_STICKY_OVERFLOW] = 1'b1;
    if (is_acc[1] && sat_ovf[1]) // see RULE9
      status_next[`SAC_ST_SECOND_ACC_STICKY_OVERFLOW] = 1'b1;
    if (v_any) // see RULE9
      status_next[`SAC_ST_VS] = 1'b1;
    if (quot_we)
      status_next[`SAC_ST_QUOT] = quot_val;
    // arithmetic never writes the condition bit
    if (cc_we) // see RULE10
      status_next[`SAC_ST_CC] = cc_val;
  end

  // read mux; unmapped addresses read as zero
  always @*
  begin
    rd_next = 32'h0;
    case (reg_addr[7:3])
      `SAC_GRP_DREG: rd_next = dreg_reg[reg_addr[2:0]];
      `SAC_GRP_DLO: rd_next = {16'h0, dreg_reg[reg_addr[2:0]][15:0]};
      `SAC_GRP_DHI: rd_next = {16'h0, dreg_reg[reg_addr[2:0]][31:16]};
      `SAC_GRP_ACC:
      begin
        case (reg_addr[1:0])
          `SAC_ACC_WORD: rd_next = acc_reg[reg_addr[2]][31:0];
          `SAC_ACC_EXT: rd_next = {24'h0, acc_reg[reg_addr[2]][39:32]};
          `SAC_ACC_LO: rd_next = {16'h0, acc_reg[reg_addr[2]][15:0]};
          default: rd_next = {16'h0, acc_reg[reg_addr[2]][31:16]};
        endcase
      end
      `SAC_GRP_PTR: rd_next = ptr_reg[reg_addr[2:0]]; // see RULE3
      `SAC_GRP_LOOP:
        if (reg_addr[2:0] <= `SAC_LOOP_CNT1)
          rd_next = loop_reg[reg_addr[2:0]];
      default:
      begin
        case (reg_addr[7:2])
          `SAC_GRP_IDX: rd_next = idx_reg[reg_addr[1:0]];
          `SAC_GRP_MOD: rd_next = mod_reg[reg_addr[1:0]];
          `SAC_GRP_LEN: rd_next = len_reg[reg_addr[1:0]];
          `SAC_GRP_BASE: rd_next = base_reg[reg_addr[1:0]];
          default:
          begin
            if (reg_addr == `SAC_OFS_STAT)
              rd_next = arith_status_word;
            else if (reg_addr == `SAC_OFS_CIRC)
              rd_next = {28'h0, circ_wrap_en};
          end
        endcase
      end
    endcase
  end

  // register file; datapath writeback is applied after the bus so a
  // same-cycle collision keeps the computed result
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        dreg_reg[i] <= 32'h0;
        ptr_reg[i] <= 32'h0;
      end
      for (i = 0; i < 6; i = i + 1)
        loop_reg[i] <= 32'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
        idx_reg[i] <= 32'h0;
        mod_reg[i] <= 32'h0;
        len_reg[i] <= 32'h0;
        base_reg[i] <= 32'h0;
      end
      acc_reg[0] <= 40'h0;
      acc_reg[1] <= 40'h0;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr[7:3])
          `SAC_GRP_DREG: dreg_reg[reg_addr[2:0]] <= reg_wr_data;
          // halves are independent; the other half is untouched
          `SAC_GRP_DLO: // see RULE2
            dreg_reg[reg_addr[2:0]][15:0] <= reg_wr_data[15:0];
          `SAC_GRP_DHI: // see RULE2
            dreg_reg[reg_addr[2:0]][31:16] <= reg_wr_data[15:0];
          `SAC_GRP_ACC:
          begin
            case (reg_addr[1:0]) // see RULE1
              `SAC_ACC_WORD:
                acc_reg[reg_addr[2]][31:0] <= reg_wr_data;
              // plain integer byte, no fractional meaning
              `SAC_ACC_EXT: // see RULE12
                acc_reg[reg_addr[2]][39:32] <= reg_wr_data[7:0];
              `SAC_ACC_LO:
                acc_reg[reg_addr[2]][15:0] <= reg_wr_data[15:0];
              default:
                acc_reg[reg_addr[2]][31:16] <= reg_wr_data[15:0];
            endcase
          end
          // whole-word only: there is no half view of a pointer
          `SAC_GRP_PTR: ptr_reg[reg_addr[2:0]] <= reg_wr_data; // see RULE3
          `SAC_GRP_LOOP: // see RULE5
            if (reg_addr[2:0] <= `SAC_LOOP_CNT1)
              loop_reg[reg_addr[2:0]] <= reg_wr_data;
          default:
          begin
            case (reg_addr[7:2]) // see RULE6
              `SAC_GRP_IDX: idx_reg[reg_addr[1:0]] <= reg_wr_data;
              `SAC_GRP_MOD: mod_reg[reg_addr[1:0]] <= reg_wr_data;
              `SAC_GRP_LEN: len_reg[reg_addr[1:0]] <= reg_wr_data;
              `SAC_GRP_BASE: base_reg[reg_addr[1:0]] <= reg_wr_data;
              default: ;
            endcase
          end
        endcase
      end
      // unit k only ever retires into accumulator k
      for (i = 0; i < 2; i = i + 1) // see RULE20
      begin
        if (op_valid[i])
        begin
          case (op_dest[3*i+:3])
            `SAC_DST_ACC: acc_reg[i] <= sat_val[40*i+:40]; // see RULE17
            // unclamped 40-bit values lose their top byte here
            `SAC_DST_DREG: // see RULE19
              dreg_reg[op_didx[3*i+:3]] <= sat_val[40*i+:32];
            `SAC_DST_DLO:
              dreg_reg[op_didx[3*i+:3]][15:0] <= sat_val[40*i+:16];
            `SAC_DST_DHI:
              dreg_reg[op_didx[3*i+:3]][31:16] <= sat_val[40*i+:16];
            default: ;
          endcase
        end
      end
      // stack holds the last used byte, so push moves down first
      if (stack_push && !stack_pop) // see RULE4
        ptr_reg[`SAC_PTR_STACK] <= ptr_reg[`SAC_PTR_STACK] -
                                   `SAC_STACK_STEP;
      else if (stack_pop && !stack_push) // see RULE4
        ptr_reg[`SAC_PTR_STACK] <= ptr_reg[`SAC_PTR_STACK] +
                                   `SAC_STACK_STEP;
    end
  end

  // two address sections working side by side; circular update math
  // lives elsewhere, this only forms the effective address
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ag_addr <= 64'h0;
      ag_valid <= 2'h0;
    end
    else
    begin
      for (g = 0; g < 2; g = g + 1) // see RULE21
      begin
        ag_valid[g] <= ag_req[g];
        if (ag_req[g])
          ag_addr[32*g+:32] <= ag_indexed[g] ?
            idx_reg[ag_ireg[2*g+:2]] + mod_reg[ag_mreg[2*g+:2]] :
            idx_reg[ag_ireg[2*g+:2]];
      end
    end
  end

  // status, read data and mirrored outputs, all from flip-flops
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      arith_status_word <= `SAC_STAT_RST;
      round_select <= 1'b0;
      condition_bit <= 1'b0;
      reg_rd_data <= 32'h0;
      circ_wrap_en <= 4'h0;
    end
    else
    begin
      arith_status_word <= status_next; // see RULE24
      // one status bit picks biased or convergent rounding downstream
      round_select <= status_next[`SAC_ST_RND]; // see RULE22
      condition_bit <= status_next[`SAC_ST_CC];
      // read data live in the cycle after the strobe only
      reg_rd_data <= reg_rd ? rd_next : 32'h0;
      for (w = 0; w < 4; w = w + 1)
        circ_wrap_en[w] <= (len_reg[w] != 32'h0); // see RULE6 see RULE23
    end
  end

  // mirrors of the pointer and accumulators, one cycle behind the file
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      stack_top_ptr <= 32'h0;
      accumulator_zero <= 40'h0;
      accumulator_one <= 40'h0;
    end
    else
    begin
      stack_top_ptr <= ptr_reg[`SAC_PTR_STACK];
      accumulator_zero <= acc_reg[0];
      accumulator_one <= acc_reg[1];
    end
  end

endmodule

// ==== bench/sac_core_chk.sv ====
`timescale 1ns/10ps

module sac_core_chk (
  input wire core_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [1:0] op_valid,
  input wire [5:0] op_dest,
  input wire [95:0] op_result,
  input wire [1:0] op_sat,
  input wire [1:0] op_sat32,
  input wire [1:0] op_uns,
  input wire cc_we,
  input wire quot_we,
  input wire stack_push,
  input wire stack_pop,
  input wire [1:0] ag_req,
  input wire [1:0] ag_valid,
  input wire [31:0] arith_status_word,
  input wire round_select,
  input wire condition_bit,
  input wire [31:0] stack_top_ptr,
  input wire [3:0] circ_wrap_en,
  input wire [39:0] accumulator_zero
);
  // a bus write to the status word may move any writable flag
  wire st_wr = reg_wr && (reg_addr == 8'h50);

  // three quiet cycles cover every mirror latency of the outputs
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_push_step:
    assert property (stack_push && !stack_pop |->
      ##2 stack_top_ptr == $past(stack_top_ptr) - 32'h00000004)
    else $error("push did not lower the stack pointer");
  a_pop_step:
    assert property (stack_pop && !stack_push |->
      ##2 stack_top_ptr == $past(stack_top_ptr) + 32'h00000004)
    else $error("pop did not raise the stack pointer");
  a_cc_quiet:
    assert property ((!cc_we && !st_wr)[*3] |-> $stable(condition_bit))
    else $error("condition bit moved without its write");
  a_flag_quiet:
    assert property ((op_valid == 2'h0 && !cc_we && !quot_we && !st_wr)[*3]
      |-> $stable(arith_status_word))
    else $error("flags moved without an arithmetic result");
  a_round_quiet:
    assert property ((!st_wr)[*3] |-> $stable(round_select))
    else $error("round select moved without a status write");
  a_circ_quiet:
    assert property ((!reg_wr)[*3] |-> $stable(circ_wrap_en))
    else $error("wrap enables moved without a write");
  a_acc_pos:
    assert property (op_valid[0] && op_dest[2:0] == 3'h1 && !op_sat32[0]
      && !op_uns[0] && !op_result[47] && op_result[46:39] != 8'h00
      |-> ##2 accumulator_zero == 40'h7fffffffff)
    else $error("positive accumulator result not clamped");
  a_acc_neg:
    assert property (op_valid[0] && op_dest[2:0] == 3'h1 && !op_sat32[0]
      && !op_uns[0] && op_result[47] && op_result[46:39] != 8'hff
      |-> ##2 accumulator_zero == 40'h8000000000)
    else $error("negative accumulator result not clamped");
  a_sticky_hold:
    assert property (arith_status_word[26] && !st_wr |=>
      arith_status_word[26])
    else $error("sticky flag dropped without a write");
  a_v_wrap:
    assert property (op_valid == 2'h1 && op_dest[2:0] == 3'h2 && !op_sat[0]
      && !op_uns[0] && op_result[47:31] != {17{op_result[47]}}
      |=> arith_status_word[24] && arith_status_word[26])
    else $error("wrapped result did not raise overflow");
  a_sat_no_v:
    assert property (op_valid == 2'h1 && op_dest[2:0] == 3'h2 && op_sat[0]
      && !st_wr |=> !arith_status_word[24])
    else $error("saturating result raised overflow");
  a_ag_both:
    assert property (ag_req == 2'h3 |=> ag_valid == 2'h3)
    else $error("address sections did not answer together");
endmodule

bind sac_core_state sac_core_chk chk_u (.core_clk(core_clk),
  .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .op_valid(op_valid), .op_dest(op_dest), .op_result(op_result),
  .op_sat(op_sat), .op_sat32(op_sat32), .op_uns(op_uns), .cc_we(cc_we),
  .quot_we(quot_we), .stack_push(stack_push), .stack_pop(stack_pop),
  .ag_req(ag_req), .ag_valid(ag_valid),
  .arith_status_word(arith_status_word), .round_select(round_select),
  .condition_bit(condition_bit), .stack_top_ptr(stack_top_ptr),
  .circ_wrap_en(circ_wrap_en), .accumulator_zero(accumulator_zero));

// ==== bench/testbench.sv ====
`timescale 1ns/10ps

module testbench;
  reg core_clk, sys_rst, reg_wr, reg_rd, quot_we, quot_val, cc_we, cc_val;
  reg stack_push, stack_pop, rd_q;
  reg [7:0] reg_addr;
  reg [31:0] reg_wr_data, d;
  reg [1:0] op_valid, op_sat, op_sat32, op_uns, op_carry, ag_req, ag_indexed;
  reg [5:0] op_dest, op_didx;
  reg [95:0] op_result;
  reg [3:0] ag_ireg, ag_mreg;
  wire [31:0] reg_rd_data, arith_status_word, stack_top_ptr;
  wire [63:0] ag_addr;
  wire [1:0] ag_valid;
  wire [3:0] circ_wrap_en;
  wire [39:0] accumulator_zero, accumulator_one;
  wire round_select, condition_bit;
  int miscompares, samples_checked, a;
  logic [31:0] exp_q[$];
  logic [31:0] mem [0:95];

  sac_core_state dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .op_valid(op_valid),
    .op_dest(op_dest), .op_didx(op_didx), .op_result(op_result),
    .op_sat(op_sat), .op_sat32(op_sat32), .op_uns(op_uns),
    .op_carry(op_carry), .quot_we(quot_we), .quot_val(quot_val),
    .cc_we(cc_we), .cc_val(cc_val), .stack_push(stack_push),
    .stack_pop(stack_pop), .ag_req(ag_req), .ag_ireg(ag_ireg),
    .ag_mreg(ag_mreg), .ag_indexed(ag_indexed), .ag_addr(ag_addr),
    .ag_valid(ag_valid), .arith_status_word(arith_status_word),
    .round_select(round_select), .condition_bit(condition_bit),
    .stack_top_ptr(stack_top_ptr), .circ_wrap_en(circ_wrap_en),
    .accumulator_zero(accumulator_zero), .accumulator_one(accumulator_one));

  // free-running 100 MHz core clock
  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // read data stand only in the cycle after the strobe, so look there
  always @(posedge core_clk)
  begin
    rd_q <= reg_rd;
    if (rd_q)
      chk({8'h00, reg_rd_data}, {8'h00, exp_q.pop_front()});
  end

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wr_data <= wd;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
  endtask

  // m packs unsigned, 32-bit clamp and saturate, in that order
  task automatic op(input logic [1:0] v, input logic [2:0] dst,
      input logic [47:0] r, input logic [2:0] m);
    @(posedge core_clk);
    op_valid <= v;
    op_dest <= {dst, dst};
    op_result <= {r, r};
    op_sat <= {2{m[0]}};
    op_sat32 <= {2{m[1]}};
    op_uns <= {2{m[2]}};
    op_carry <= v;
    @(posedge core_clk);
    op_valid <= 2'h0;
    #1;
  endtask

  task automatic sat(input logic [2:0] dst, input logic [47:0] r,
      input logic [2:0] m, input logic [7:0] ad, input logic [31:0] e,
      input logic [1:0] v);
    op(2'h1, dst, r, m);
    if (v[1])
      chk(arith_status_word[24], v[0]);
    rd(ad, e);
  endtask

  // one cycle of push and pop, then wait out the mirror
  task automatic pulse(input logic pu, input logic po);
    @(posedge core_clk);
    stack_push <= pu;
    stack_pop <= po;
    @(posedge core_clk);
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang past 100 us is far beyond the few hundred cycles planned
  initial
  begin
    #100000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test;
  end

  // main sequence, all inputs quiet at time zero
  initial
  begin
    {core_clk, reg_wr, reg_rd, quot_we, quot_val, cc_we, cc_val} = 7'h00;
    {stack_push, stack_pop, reg_addr, reg_wr_data} = 42'h0;
    {op_valid, op_sat, op_sat32, op_uns, op_carry, ag_req} = 12'h000;
    {ag_indexed, op_dest, ag_ireg, ag_mreg} = 16'h0;
    op_result = 96'h0;
    op_didx = 6'h08;
    sys_rst = 1'b1;
    d = $urandom(72);
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h50, 32'h0);
    $display("reset test done");
    d = $urandom;
    wr(8'h03, d);
    rd(8'h0b, {16'h0, d[15:0]});
    rd(8'h13, {16'h0, d[31:16]});
    wr(8'h0b, 32'h0000beef);
    rd(8'h03, {d[31:16], 16'hbeef});
    d = $urandom;
    wr(8'h20, d);
    wr(8'h21, 32'h000000a5);
    rd(8'h22, {16'h0, d[15:0]});
    rd(8'h23, {16'h0, d[31:16]});
    chk(accumulator_zero, {8'ha5, d});
    $display("register view test done");
    for (a = 8'h30; a < 8'h50; a++)
    begin
      d = $urandom;
      mem[a] = (a == 8'h3e || a == 8'h3f) ? 32'h0 : d;
      wr(a[7:0], d);
    end
    for (a = 8'h30; a < 8'h50; a++)
      rd(a[7:0], mem[a]);
    wr(8'h48, 32'h0);
    wr(8'h49, 32'h40);
    wr(8'h4a, 32'h0);
    wr(8'h4b, 32'h1);
    wr(8'h51, 32'hf);
    rd(8'h51, 32'ha);
    chk(circ_wrap_en, 4'ha);
    $display("register file test done");
    wr(8'h36, 32'h00001000);
    pulse(1'b1, 1'b0);
    chk(stack_top_ptr, 32'h00000ffc);
    pulse(1'b1, 1'b1);
    pulse(1'b0, 1'b1);
    chk(stack_top_ptr, 32'h00001000);
    @(posedge core_clk);
    ag_req <= 2'h3;
    ag_ireg <= 4'hd;
    ag_mreg <= 4'h8;
    ag_indexed <= 2'h2;
    @(posedge core_clk);
    ag_req <= 2'h0;
    #1;
    chk(ag_addr[31:0], mem[8'h41]);
    chk(ag_addr[63:32], 32'(mem[8'h43] + mem[8'h46]));
    chk(ag_valid, 2'h3);
    chk(arith_status_word, 32'h0);
    $display("pointer test done");
    sat(3'h2, 48'h00ab12345678, 3'h0, 8'h00, 32'h12345678, 2'h3);
    sat(3'h2, 48'h000100000000, 3'h1, 8'h00, 32'h7fffffff, 2'h2);
    sat(3'h2, 48'hffff00000000, 3'h1, 8'h00, 32'h80000000, 2'h2);
    sat(3'h2, 48'h000100000000, 3'h5, 8'h00, 32'hffffffff, 2'h2);
    sat(3'h3, 48'h000000012345, 3'h1, 8'h08, 32'h00007fff, 2'h0);
    sat(3'h4, 48'hfffffffe0000, 3'h1, 8'h10, 32'h00008000, 2'h0);
    sat(3'h1, 48'h010000000000, 3'h0, 8'h21, 32'h0000007f, 2'h0);
    sat(3'h1, 48'h800000000000, 3'h0, 8'h21, 32'h00000080, 2'h0);
    chk(arith_status_word[26], 1'b1);
    wr(8'h50, 32'h0);
    chk(arith_status_word[26], 1'b0);
    op(2'h2, 3'h1, 48'h010000000000, 3'h2);
    rd(8'h24, 32'h7fffffff);
    rd(8'h21, 32'h00000080);
    chk(accumulator_one, 40'h007fffffff);
    $display("saturation test done");
    @(posedge core_clk);
    cc_we <= 1'b1;
    cc_val <= 1'b1;
    quot_we <= 1'b1;
    quot_val <= 1'b1;
    @(posedge core_clk);
    cc_we <= 1'b0;
    quot_we <= 1'b0;
    op(2'h1, 3'h0, 48'h0, 3'h0);
    repeat (2) @(posedge core_clk);
    #1;
    chk(condition_bit, 1'b1);
    // zero, cond, quotient, both unit-zero carries and the unit-one carry
    rd(8'h50, 32'h00007061);
    wr(8'h50, 32'h00000100);
    repeat (2) @(posedge core_clk);
    #1;
    chk(round_select, 1'b1);
    chk(condition_bit, 1'b0);
    $display("condition test done");
    end_of_test;
  end
endmodule
